// *** pkg/ocl_pkg.sv ***
// Purpose: shared constants and types for the configuration loader
// Assumes: store words are 16 bits, read one address per request
// Notes: store map and default image are local choices
package ocl_pkg;
    localparam int OCL_AW = 4;
    localparam int OCL_DW = 16;
    localparam int OCL_WORDS = 8;
    // word addresses in the configuration store
    localparam logic [3:0] OCL_A_VENDOR = 4'h0;
    localparam logic [3:0] OCL_A_PRODUCT = 4'h1;
    localparam logic [3:0] OCL_A_POWER = 4'h2;
    localparam logic [3:0] OCL_A_FLAGS = 4'h3;
    localparam logic [3:0] OCL_A_PINS = 4'h4;
    localparam logic [3:0] OCL_A_GPIO = 4'h5;
    localparam logic [3:0] OCL_A_LAST = 4'h5;
    // fixed bus specification version
    localparam logic [15:0] OCL_BUS_VERSION = 16'h0200;
    // power word: bit 15 self-powered, bits 9:0 current in mA
    localparam int OCL_P_SELF = 15;
    localparam int OCL_P_MA_W = 10;
    localparam logic [9:0] OCL_MA_MAX = 10'h1f4;
    localparam logic [9:0] OCL_MA_DEF = 10'h064;
    // flags word bit positions
    localparam int OCL_F_WAKE = 0;
    localparam int OCL_F_SERIAL = 1;
    localparam int OCL_F_SUSP_EN = 2;
    localparam int OCL_F_SUSP_POL = 3;
    localparam int OCL_F_OPEN_DRAIN = 4;
    localparam int OCL_F_CHG_DIS = 5;
    localparam int OCL_F_CHG_POL = 6;
    localparam int OCL_F_EDGE_FALL = 7;
    localparam int OCL_F_ADDR_LSB = 8;
    localparam int OCL_ADDR_W = 7;
    localparam logic [6:0] OCL_ADDR_DEF = 7'h40;
    // pins word: bit 0 serial pin control, then two bits per serial pin
    localparam int OCL_N_SER = 6;
    localparam int OCL_N_GPIO = 4;
    localparam int OCL_SUSP_GPIO = 2;
    localparam int OCL_WAKE_GPIO = 3;
    // suspend pin actions
    typedef enum logic [1:0] {
        OCL_KEEP = 2'h0,
        OCL_TRISTATE = 2'h1,
        OCL_HIGH = 2'h2,
        OCL_LOW = 2'h3
    } ocl_act_e;
    typedef struct packed {
        logic [15:0] vendor_identifier;
        logic [15:0] product_identifier;
        logic [15:0] bus_version;
        logic self_powered;
        logic [9:0] max_current_ma;
        logic remote_wake;
        logic serial_string;
        logic suspend_out_en;
        logic suspend_out_pol;
        logic [6:0] slave_addr;
        logic gpio_open_drain;
        logic charger_en;
        logic charger_pol;
        logic wake_falling;
    } ocl_desc_s;
    typedef struct packed {
        logic out;
        logic oe;
    } ocl_pin_s;
    // defaults used when the store image is taken from nothing
    // wake on, indicator on and active high, charger active high, addr 40h
    localparam logic [15:0] OCL_DEF_FLAGS = 16'h404d;
    localparam logic [15:0] OCL_DEF_PINS = 16'h0000;
    localparam logic [15:0] OCL_DEF_GPIO = 16'h0055;
    localparam logic [15:0] OCL_DEF_POWER = {6'h00, OCL_MA_DEF};
    localparam logic [15:0] OCL_DEF_ID = 16'h1234;
endpackage

// *** rtl/ocl_store.sv ***
// Purpose: configuration store image with registered read data
// Assumes: contents fixed at build time through the image parameter
// Notes: one-cycle read latency
`timescale 1ns/1ps
`default_nettype none
module ocl_store
    import ocl_pkg::*;
#(
    parameter logic [OCL_WORDS*OCL_DW-1:0] IMAGE = '0
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // read port
    input wire logic [OCL_AW-1:0] i_addr,
    output logic [OCL_DW-1:0] o_data
);
    logic [OCL_DW-1:0] mem [OCL_WORDS];
    genvar g;
    generate
        for (g = 0; g < OCL_WORDS; g++) begin : g_word
            assign mem[g] = IMAGE[g*OCL_DW +: OCL_DW];
        end
    endgenerate
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_data <= '0;
        end else begin
            o_data <= mem[i_addr[2:0]];
        end
    end
endmodule // ocl_store
`default_nettype wire

// *** rtl/ocl_suspend_pin.sv ***
// Purpose: one pad's drive during bus suspend
// Assumes: normal drive comes from the function logic
// Notes: keep freezes the value held at suspend entry
`timescale 1ns/1ps
`default_nettype none
module ocl_suspend_pin
    import ocl_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // control
    input wire logic i_suspend,
    input wire logic i_ctrl,
    input wire logic [1:0] i_act,
    input wire logic i_open_drain,
    // pad
    input wire ocl_pin_s i_normal,
    output ocl_pin_s o_pad
);
    logic was_susp;
    ocl_pin_s held;
    ocl_pin_s next_pad;
    ocl_pin_s susp_drive;
    wire entry = i_suspend & ~was_susp;
    always_comb begin
        case (ocl_act_e'(i_act))
            OCL_KEEP: susp_drive = entry ? i_normal : held;
            OCL_TRISTATE: susp_drive = '{out: 1'b0, oe: 1'b0};
            OCL_HIGH: susp_drive = '{out: 1'b1, oe: 1'b1};
            OCL_LOW: susp_drive = '{out: 1'b0, oe: 1'b1};
            default: susp_drive = '{out: 1'b0, oe: 1'b0};
        endcase
    end
    wire ocl_pin_s pre = (i_suspend & i_ctrl) ? susp_drive : i_normal;
    // open drain only pulls low; a high becomes release
    assign next_pad.out = i_open_drain ? 1'b0 : pre.out;
    assign next_pad.oe = i_open_drain ? (pre.oe & ~pre.out) : pre.oe;
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            was_susp <= 1'b0;
            held <= '0;
            o_pad <= '0;
        end else begin
            was_susp <= i_suspend;
            if (entry) begin
                held <= i_normal;
            end
            o_pad <= next_pad;
        end
    end
endmodule // ocl_suspend_pin
`default_nettype wire

// *** rtl/otp_config_loader.sv ***
// Purpose: load descriptor and pin configuration from the store
// Assumes: 40 MHz clock; bus reset arrives as a one-cycle pulse
// Notes: requests are held off until the load finishes
`timescale 1ns/1ps
`default_nettype none
module otp_config_loader
    import ocl_pkg::*;
#(
    parameter logic [OCL_WORDS*OCL_DW-1:0] IMAGE = {
        16'h0000, 16'h0000, OCL_DEF_GPIO, OCL_DEF_PINS,
        OCL_DEF_FLAGS, OCL_DEF_POWER, OCL_DEF_ID, OCL_DEF_ID}
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // bus events
    input wire logic i_bus_reset,
    input wire logic i_suspend,
    input wire logic i_full_speed_only,
    input wire logic i_dedicated_charger,
    input wire logic i_enumerated,
    // normal drive of serial pins and gpios, and the wake pin level
    input wire ocl_pin_s [OCL_N_SER-1:0] i_ser_normal,
    input wire ocl_pin_s [OCL_N_GPIO-1:0] i_gpio_normal,
    input wire logic i_wake_pin,
    // loaded configuration and bus speed
    output logic o_ready,
    output ocl_desc_s o_desc,
    output logic o_high_speed,
    // pads
    output ocl_pin_s [OCL_N_SER-1:0] o_ser_pad,
    output ocl_pin_s [OCL_N_GPIO-1:0] o_gpio_pad,
    output logic o_charger_detect_output,
    output logic o_wake_event
);
    ////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_READ = 2'b11,
        ST_DONE = 2'b10
    } ocl_state_e;
    ocl_state_e state;
    ocl_state_e next_state;
    logic [OCL_AW-1:0] addr;
    logic [OCL_AW-1:0] cap_addr;
    logic [OCL_DW-1:0] rdata;
    logic [OCL_DW-1:0] w_vendor;
    logic [OCL_DW-1:0] w_product;
    logic [OCL_DW-1:0] w_power;
    logic [OCL_DW-1:0] w_flags;
    logic [OCL_DW-1:0] w_pins;
    logic [OCL_DW-1:0] w_gpio;
    logic wake_prev;
    ocl_store #(
        .IMAGE(IMAGE)
    ) u_store (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_addr(addr),
        .o_data(rdata)
    );
    ////////////////////////////////////////////////////////////////
    // load sequence; a bus reset restarts it at any point
    always_comb begin
        case (state)
            ST_IDLE: next_state = ST_ADDR;
            ST_ADDR: next_state = ST_READ;
            ST_READ: next_state = (cap_addr == OCL_A_LAST) ? ST_DONE
                                                           : ST_READ;
            ST_DONE: next_state = ST_DONE;
            default: next_state = ST_IDLE;
        endcase
        if (i_bus_reset) begin
            next_state = ST_IDLE;
        end
    end
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            state <= ST_IDLE;
            addr <= '0;
            cap_addr <= '0;
        end else begin
            state <= next_state;
            if (next_state == ST_IDLE) begin
                addr <= '0;
            end else if (addr != OCL_A_LAST) begin
                addr <= addr + 4'h1;
            end
            cap_addr <= addr;
        end
    end
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            w_vendor <= '0;
            w_product <= '0;
            w_power <= '0;
            w_flags <= '0;
            w_pins <= '0;
            w_gpio <= '0;
        // word 0 leaves the store while the sequence is still in ADDR
        end else if (state == ST_ADDR || state == ST_READ) begin
            case (cap_addr)
                OCL_A_VENDOR: w_vendor <= rdata;
                OCL_A_PRODUCT: w_product <= rdata;
                OCL_A_POWER: w_power <= rdata;
                OCL_A_FLAGS: w_flags <= rdata;
                OCL_A_PINS: w_pins <= rdata;
                OCL_A_GPIO: w_gpio <= rdata;
                default: w_flags <= w_flags;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    // descriptor decode
    wire self_pw = w_power[OCL_P_SELF];
    wire [9:0] raw_ma = w_power[OCL_P_MA_W-1:0];
    // out-of-range current saturates rather than over-promising
    wire [9:0] lim_ma = (raw_ma > OCL_MA_MAX) ? OCL_MA_MAX : raw_ma;
    ocl_desc_s next_desc;
    assign next_desc.vendor_identifier = w_vendor;
    assign next_desc.product_identifier = w_product;
    assign next_desc.bus_version = OCL_BUS_VERSION;
    assign next_desc.self_powered = self_pw;
    assign next_desc.max_current_ma = self_pw ? '0 : lim_ma;
    assign next_desc.remote_wake = w_flags[OCL_F_WAKE];
    assign next_desc.serial_string = w_flags[OCL_F_SERIAL];
    assign next_desc.suspend_out_en = w_flags[OCL_F_SUSP_EN];
    assign next_desc.suspend_out_pol = w_flags[OCL_F_SUSP_POL];
    assign next_desc.slave_addr =
        w_flags[OCL_F_ADDR_LSB +: OCL_ADDR_W];
    assign next_desc.gpio_open_drain = w_flags[OCL_F_OPEN_DRAIN];
    assign next_desc.charger_en = ~w_flags[OCL_F_CHG_DIS];
    assign next_desc.charger_pol = w_flags[OCL_F_CHG_POL];
    assign next_desc.wake_falling = w_flags[OCL_F_EDGE_FALL];
    wire loaded = (state == ST_DONE);
    ////////////////////////////////////////////////////////////////
    // pads: suspend actions only once the configuration is valid
    wire susp_act = i_suspend & loaded;
    genvar g;
    generate
        for (g = 0; g < OCL_N_SER; g++) begin : g_ser
            ocl_suspend_pin u_pin (
                .i_clock(i_clock),
                .i_reset(i_reset),
                .i_suspend(susp_act),
                .i_ctrl(1'b1),
                // without pin control the serial pins float
                .i_act(w_pins[0] ? w_pins[2*g+1 +: 2]
                                 : 2'(OCL_TRISTATE)),
                .i_open_drain(1'b0),
                .i_normal(i_ser_normal[g]),
                .o_pad(o_ser_pad[g])
            );
        end
        for (g = 0; g < OCL_N_GPIO; g++) begin : g_gpio
            // suspend indicator pin replaces its normal drive
            wire is_ind = (g == OCL_SUSP_GPIO) & next_desc.suspend_out_en
                & loaded;
            wire ocl_pin_s norm = is_ind ?
                ocl_pin_s'{out: susp_act ~^ next_desc.suspend_out_pol,
                  oe: 1'b1} : i_gpio_normal[g];
            ocl_suspend_pin u_pin (
                .i_clock(i_clock),
                .i_reset(i_reset),
                .i_suspend(susp_act),
                .i_ctrl(~is_ind),
                .i_act(w_gpio[2*g +: 2]),
                .i_open_drain(next_desc.gpio_open_drain & loaded),
                .i_normal(norm),
                .o_pad(o_gpio_pad[g])
            );
        end
    endgenerate
    ////////////////////////////////////////////////////////////////
    // charger detect and wake edge
    wire chg_on = loaded & next_desc.charger_en & i_suspend
        & i_dedicated_charger & ~i_enumerated;
    wire next_chg = chg_on ~^ next_desc.charger_pol;
    wire wake_edge = next_desc.wake_falling ? (wake_prev & ~i_wake_pin)
                                            : (~wake_prev & i_wake_pin);
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_ready <= 1'b0;
            o_desc <= '0;
            o_high_speed <= 1'b0;
            o_charger_detect_output <= 1'b0;
            wake_prev <= 1'b0;
            o_wake_event <= 1'b0;
        end else begin
            o_ready <= loaded & ~i_bus_reset;
            o_desc <= next_desc;
            o_high_speed <= ~i_full_speed_only;
            o_charger_detect_output <= loaded ? next_chg : 1'b0;
            wake_prev <= i_wake_pin;
            o_wake_event <= loaded & wake_edge;
        end
    end
endmodule // otp_config_loader
`default_nettype wire

// *** sim/ocl_checker.sv ***
// Purpose: port-level properties of the configuration loader
// Assumes: one clock, asynchronous active-high reset
// Notes: bound to every loader instance
`timescale 1ns/1ps
`default_nettype none
module ocl_checker
    import ocl_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // bus events
    input wire logic i_bus_reset,
    input wire logic i_suspend,
    input wire logic i_full_speed_only,
    input wire logic i_dedicated_charger,
    input wire logic i_enumerated,
    // outputs watched
    input wire logic o_ready,
    input wire ocl_desc_s o_desc,
    input wire logic o_high_speed,
    input wire ocl_pin_s [OCL_N_GPIO-1:0] o_gpio_pad,
    input wire logic o_charger_detect_output
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////////////////////////////////////
    sequence s_reload;
        $fell(i_bus_reset);
    endsequence
    sequence s_loaded;
        o_ready && $past(o_ready) && o_desc.charger_en;
    endsequence
    sequence s_charge_on;
        s_loaded ##0 ($past(i_suspend) && $past(i_dedicated_charger)
            && !$past(i_enumerated));
    endsequence
    sequence s_charge_off;
        s_loaded ##0 (!$past(i_suspend) || !$past(i_dedicated_charger)
            || $past(i_enumerated));
    endsequence
    sequence s_suspended;
        o_ready && $past(o_ready) && o_desc.suspend_out_en
            && i_suspend && $past(i_suspend);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    ready_drop_a: assert property (i_bus_reset |=> !o_ready)
        else $error("ready kept through bus reset");
    reload_time_a: assert property (s_reload |-> ##[0:16] o_ready)
        else $error("reload did not finish in time");
    bus_version_a: assert property (o_ready |-> o_desc.bus_version == 16'h0200)
        else $error("bus version not 0200");
    self_zero_a: assert property (o_ready && o_desc.self_powered
        |-> o_desc.max_current_ma == 10'h000) else $error("self current");
    current_max_a: assert property (o_ready
        |-> o_desc.max_current_ma <= 10'h1f4) else $error("current range");
    hs_follow_a: assert property (1'b1
        |=> o_high_speed == !$past(i_full_speed_only)) else $error("speed");
    charge_on_a: assert property (s_charge_on
        |-> o_charger_detect_output == o_desc.charger_pol)
        else $error("charger output not active");
    charge_off_a: assert property (s_charge_off
        |-> o_charger_detect_output == !o_desc.charger_pol)
        else $error("charger output not idle");
    ind_level_a: assert property (s_suspended
        |-> o_gpio_pad[OCL_SUSP_GPIO].out == o_desc.suspend_out_pol)
        else $error("suspend indicator level");
    idle_charger_a: assert property (!o_ready && !$past(o_ready)
        |-> !o_charger_detect_output) else $error("charger before load");
endmodule // ocl_checker
bind otp_config_loader ocl_checker i_chk (.i_clock(i_clock),
    .i_reset(i_reset), .i_bus_reset(i_bus_reset), .i_suspend(i_suspend),
    .i_full_speed_only(i_full_speed_only),
    .i_dedicated_charger(i_dedicated_charger), .i_enumerated(i_enumerated),
    .o_ready(o_ready), .o_desc(o_desc), .o_high_speed(o_high_speed),
    .o_gpio_pad(o_gpio_pad),
    .o_charger_detect_output(o_charger_detect_output));
`default_nettype wire

// *** sim/ocl_host.sv ***
// Purpose: host side model giving bus events to the loader
// Assumes: events change just after a rising edge
// Notes: bus reset is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module ocl_host (
    // clock
    input wire logic i_clock,
    // bus events toward the device
    output logic o_bus_reset,
    output logic o_suspend,
    output logic o_full_speed_only,
    output logic o_dedicated_charger,
    output logic o_enumerated
);
    initial begin
        {o_bus_reset, o_suspend, o_full_speed_only} = 3'h0;
        {o_dedicated_charger, o_enumerated} = 2'h0;
    end
    task automatic bus_reset();
        @(posedge i_clock);
        o_bus_reset <= 1'b1;
        @(posedge i_clock);
        o_bus_reset <= 1'b0;
    endtask
    // levels move together so one edge sees a consistent bus state
    task automatic drive(input logic s, input logic f, input logic d,
        input logic e);
        @(posedge i_clock);
        o_suspend <= s;
        o_full_speed_only <= f;
        o_dedicated_charger <= d;
        o_enumerated <= e;
    endtask
endmodule // ocl_host
`default_nettype wire

// *** sim/testbench.sv ***
// Purpose: directed bench for the configuration loader
// Assumes: one factory image and one custom image, side by side
// Notes: host model drives the bus events
`timescale 1ns/1ps
`default_nettype none
module testbench import ocl_pkg::*; ;
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[ERR] %s expected %h seen %h", nm, e, g); \
    end end
    localparam logic [OCL_WORDS*OCL_DW-1:0] IMG_DEF = {32'h0, OCL_DEF_GPIO,
        OCL_DEF_PINS, OCL_DEF_FLAGS, OCL_DEF_POWER, OCL_DEF_ID, OCL_DEF_ID};
    // self-powered with 500 mA stored: must still report zero
    localparam logic [OCL_WORDS*OCL_DW-1:0] IMG_ALT = {32'h0, 16'h0078,
        16'h0771, 16'h7f96, 16'h81f4, 16'h0a5c, 16'hbeef};
    localparam ocl_desc_s EXP_DEF = '{16'h1234, 16'h1234, 16'h0200, 1'b0,
        10'h064, 1'b1, 1'b0, 1'b1, 1'b1, 7'h40, 1'b0, 1'b1, 1'b1, 1'b0};
    localparam ocl_desc_s EXP_ALT = '{16'hbeef, 16'h0a5c, 16'h0200, 1'b1,
        10'h000, 1'b0, 1'b1, 1'b1, 1'b0, 7'h7f, 1'b1, 1'b1, 1'b0, 1'b1};
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic wake = 1'b0;
    int n_mismatch = 0;
    int checked = 0;
    int n_wake [2] = '{0, 0};
    ocl_pin_s [OCL_N_SER-1:0] ser_n = '0;
    ocl_pin_s [OCL_N_GPIO-1:0] gpio_n = '0;
    wire bus_rst, susp, fso, dchg, enumd;
    wire [1:0] rdy, hs, chg, wk;
    wire ocl_desc_s [1:0] desc;
    wire ocl_pin_s [1:0][OCL_N_SER-1:0] ser_p;
    wire ocl_pin_s [1:0][OCL_N_GPIO-1:0] gp_p;
    ////////////////////////////////////////////////////////////////////////
    initial forever #12.5 i_clock = ~i_clock;
    always @(posedge i_clock) for (int k = 0; k < 2; k++) n_wake[k] += wk[k];
    ocl_host i_host (.i_clock(i_clock), .o_bus_reset(bus_rst),
        .o_suspend(susp), .o_full_speed_only(fso),
        .o_dedicated_charger(dchg), .o_enumerated(enumd));
    for (genvar k = 0; k < 2; k++) begin : g_dut
        otp_config_loader #(.IMAGE(k ? IMG_ALT : IMG_DEF)) i_dut (
            .i_clock(i_clock), .i_reset(i_reset), .i_bus_reset(bus_rst),
            .i_suspend(susp), .i_full_speed_only(fso),
            .i_dedicated_charger(dchg), .i_enumerated(enumd),
            .i_ser_normal(ser_n), .i_gpio_normal(gpio_n),
            .i_wake_pin(wake), .o_ready(rdy[k]), .o_desc(desc[k]),
            .o_high_speed(hs[k]), .o_ser_pad(ser_p[k]),
            .o_gpio_pad(gp_p[k]), .o_charger_detect_output(chg[k]),
            .o_wake_event(wk[k]));
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wait_ready();
        int t;
        t = 0;
        while (rdy !== 2'b11 && t < 40) begin
            tick(1);
            t++;
        end
        if (rdy !== 2'b11) begin
            n_mismatch++;
            conclude();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge i_clock);
        i_reset <= 1'b0;
        wait_ready();
        `CHK("desc_def", EXP_DEF, desc[0]);
        `CHK("desc_alt", EXP_ALT, desc[1]);
        $display("test load done");
        i_host.bus_reset();
        tick(1);
        `CHK("ready_drop", 2'b00, rdy);
        wait_ready();
        `CHK("desc_reload", EXP_ALT, desc[1]);
        $display("test bus reset done");
        i_host.drive(1'b0, 1'b1, 1'b0, 1'b0);
        tick(2);
        `CHK("full_speed", 2'b00, hs);
        `CHK("fs_version", 16'h0200, desc[1].bus_version);
        i_host.drive(1'b0, 1'b0, 1'b0, 1'b0);
        tick(2);
        `CHK("high_speed", 2'b11, hs);
        $display("test speed done");
        @(posedge i_clock);
        ser_n <= {OCL_N_SER{2'b11}};
        gpio_n <= {OCL_N_GPIO{2'b11}};
        i_host.drive(1'b1, 1'b0, 1'b1, 1'b0);
        tick(3);
        // keep must ignore drive changes made after suspend entry
        ser_n <= {OCL_N_SER{2'b01}};
        gpio_n <= {OCL_N_GPIO{2'b01}};
        tick(2);
        for (int i = 0; i < OCL_N_SER; i++) `CHK("ser_oe", 1'b0, ser_p[0][i].oe);
        `CHK("ser_alt", 12'hddf, ser_p[1]);
        for (int i = 0; i < 4; i++) if (i != 2) `CHK("gp_oe", 1'b0, gp_p[0][i].oe);
        `CHK("ind_def", 2'b11, gp_p[0][2]);
        `CHK("ind_alt", 1'b0, gp_p[1][2].out);
        `CHK("od_high", 1'b0, gp_p[1][1].oe);
        `CHK("gp_tri", 1'b0, gp_p[1][3].oe);
        `CHK("gp_keep", 2'b00, gp_p[1][0]);
        `CHK("chg_dcp", 2'b01, chg);
        i_host.drive(1'b1, 1'b0, 1'b1, 1'b1);
        tick(3);
        `CHK("chg_enum", 2'b10, chg);
        i_host.drive(1'b0, 1'b0, 1'b0, 1'b0);
        tick(3);
        `CHK("resume", {12{2'b01}}, ser_p);
        $display("test suspend done");
        n_wake = '{0, 0};
        @(posedge i_clock);
        wake <= 1'b1;
        tick(6);
        `CHK("wake_rise", 1, n_wake[0]);
        `CHK("wake_rise_alt", 0, n_wake[1]);
        n_wake = '{0, 0};
        @(posedge i_clock);
        wake <= 1'b0;
        tick(6);
        `CHK("wake_fall", 0, n_wake[0]);
        `CHK("wake_fall_alt", 1, n_wake[1]);
        $display("test wake done");
        conclude();
    end
endmodule // testbench
`default_nettype wire
